/* csd_pkg.sv */
// Package of encodings, field positions and the pointer step for the subtract decoder pair.
package csd_pkg;

	// Instruction word field positions.
	localparam int SEL_HI   = 31;
	localparam int SEL_LO   = 29;
	localparam int SRC1_HI  = 28;
	localparam int SRC1_LO  = 25;
	localparam int SRC2_HI  = 24;
	localparam int SRC2_LO  = 21;
	localparam int DST_HI   = 20;
	localparam int DST_LO   = 16;
	localparam int GRP_HI   = 15;
	localparam int GRP_LO   = 12;
	localparam int OPC_HI   = 11;
	localparam int OPC_LO   = 9;
	localparam int TYPE_BIT = 8;
	localparam int SIZE_BIT = 7;

	// Opcode group nibble: register-only, host-register load, memory load.
	localparam logic [3:0] GRP_REG  = 4'h0;
	localparam logic [3:0] GRP_HOST = 4'h4;
	localparam logic [3:0] GRP_MEM  = 4'h8;

	// Upper three bits of the second opcode nibble; the magnitude code is the whole nibble.
	localparam logic [2:0] OPC_ONE_MINUS_TWO = 3'h1;
	localparam logic [2:0] OPC_TWO_MINUS_ONE = 3'h3;
	localparam logic [3:0] OPC_MAGNITUDE     = 4'hB;

	// Pointer step in bits for memory loads.
	localparam logic [31:0] PTR_STEP = 32'h00000020;

	// Operation codes decoded from the instruction word inside the coprocessor.
	typedef enum logic [2:0] {
		CSD_OP_NONE       = 3'b000,
		CSD_OP_ONE_TWO    = 3'b001,
		CSD_OP_TWO_ONE    = 3'b010,
		CSD_OP_MAGNITUDE  = 3'b011
	} csd_op_t;

	// Source of operand words for one instruction.
	typedef enum logic [1:0] {
		CSD_SRC_NONE = 2'b00,
		CSD_SRC_HOST = 2'b01,
		CSD_SRC_POST = 2'b10,
		CSD_SRC_PRE  = 2'b11
	} csd_src_t;

endpackage

/* csd_link_if.sv */
// Interface carrying instruction words and operand words from host to coprocessor.
interface csd_link_if;
	logic        instr_valid;
	logic [31:0] instr;
	logic        instr_ready;
	logic        data_valid;
	logic [31:0] data;
	logic        data_ready;
	logic        done;
	logic        illegal;

	// Host end drives words and reads the completion pulses.
	modport host_mp (
		output instr_valid,
		output instr,
		input  instr_ready,
		output data_valid,
		output data,
		input  data_ready,
		input  done,
		input  illegal
	);

	// Coprocessor end takes words and reports completion.
	modport dev_mp (
		input  instr_valid,
		input  instr,
		output instr_ready,
		input  data_valid,
		input  data,
		output data_ready,
		output done,
		output illegal
	);
endinterface

/* csd_host.sv */
// Host end: issues subtract instructions, moves operands and keeps the memory pointer.
module csd_host #(
	parameter int DATA_W = 32
) (
	input  wire logic              sys_clk_i,
	input  wire logic              arst_n_i,
	csd_link_if.host_mp            link,
	input  wire logic              req_valid_i,
	input  wire logic [31:0]       req_instr_i,
	input  wire csd_pkg::csd_src_t req_src_i,
	input  wire logic [DATA_W-1:0] req_first_i,
	input  wire logic [DATA_W-1:0] req_second_i,
	input  wire logic [31:0]       req_ptr_i,
	output logic                   req_ready_o,
	output logic [31:0]            mem_addr_o,
	output logic                   mem_rd_o,
	input  wire logic [DATA_W-1:0] mem_data_i,
	output logic [31:0]            ptr_o,
	output logic                   busy_o
);

	typedef enum logic [2:0] {
		HST_IDLE  = 3'b000,
		HST_INSTR = 3'b001,
		HST_FIRST = 3'b010,
		HST_SECND = 3'b011,
		HST_WAIT  = 3'b100
	} hst_state_t;

	hst_state_t        state_reg, state_next;
	csd_pkg::csd_src_t src_reg, src_next;
	logic [31:0]       instr_reg, instr_next;
	logic [31:0]       ptr_reg, ptr_next;
	logic [DATA_W-1:0] v1_reg, v1_next;
	logic [DATA_W-1:0] v2_reg, v2_next;
	logic [DATA_W-1:0] word_reg, word_next;
	logic              wvalid_reg, wvalid_next;

	// Memory fetch address: predecrement reads below the pointer, postincrement reads at it.
	always_comb begin
		mem_addr_o = (src_reg == csd_pkg::CSD_SRC_PRE) ? ptr_reg - csd_pkg::PTR_STEP : ptr_reg;
		mem_rd_o   = (state_reg == HST_FIRST || state_reg == HST_SECND) && !wvalid_reg
		             && !link.illegal
		             && (src_reg == csd_pkg::CSD_SRC_POST || src_reg == csd_pkg::CSD_SRC_PRE);
	end

	assign req_ready_o      = (state_reg == HST_IDLE);
	assign busy_o           = (state_reg != HST_IDLE);
	assign ptr_o            = ptr_reg;
	assign link.instr_valid = (state_reg == HST_INSTR);
	assign link.instr       = instr_reg;
	assign link.data_valid  = wvalid_reg;
	assign link.data        = word_reg;

	// Sequencer: instruction word, then up to two operand words, then wait for completion.
	// Memory reads are assumed to return data in the same cycle as the strobe.
	always_comb begin
		state_next  = state_reg;
		src_next    = src_reg;
		instr_next  = instr_reg;
		ptr_next    = ptr_reg;
		v1_next     = v1_reg;
		v2_next     = v2_reg;
		word_next   = word_reg;
		wvalid_next = wvalid_reg;
		case (state_reg)
			HST_IDLE: begin
				if (req_valid_i) begin
					instr_next = req_instr_i;
					src_next   = req_src_i;
					ptr_next   = req_ptr_i;
					v1_next    = req_first_i;
					v2_next    = req_second_i;
					state_next = HST_INSTR;
				end
			end
			HST_INSTR: begin
				if (link.instr_ready) begin
					state_next = (src_reg == csd_pkg::CSD_SRC_NONE) ? HST_WAIT : HST_FIRST;
				end
			end
			HST_FIRST, HST_SECND: begin
				// A refused instruction never asks for operands, so drop the transfer at once.
				if (link.illegal) begin
					wvalid_next = 1'b0;
					state_next  = HST_IDLE;
				end else if (!wvalid_reg) begin
					wvalid_next = 1'b1;
					if (src_reg == csd_pkg::CSD_SRC_HOST) begin
						word_next = (state_reg == HST_FIRST) ? v1_reg : v2_reg;
					end else begin
						word_next = mem_data_i;
						if (src_reg == csd_pkg::CSD_SRC_POST) begin
							ptr_next = ptr_reg + csd_pkg::PTR_STEP;
						end else begin
							ptr_next = ptr_reg - csd_pkg::PTR_STEP;
						end
					end
				end else if (link.data_ready) begin
					wvalid_next = 1'b0;
					state_next  = (state_reg == HST_FIRST) ? HST_SECND : HST_WAIT;
				end
			end
			HST_WAIT: begin
				if (link.done || link.illegal) begin
					state_next = HST_IDLE;
				end
			end
			default: state_next = HST_IDLE;
		endcase
	end

	// State registers.
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg  <= HST_IDLE;
			src_reg    <= csd_pkg::CSD_SRC_NONE;
			instr_reg  <= '0;
			ptr_reg    <= '0;
			v1_reg     <= '0;
			v2_reg     <= '0;
			word_reg   <= '0;
			wvalid_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			src_reg    <= src_next;
			instr_reg  <= instr_next;
			ptr_reg    <= ptr_next;
			v1_reg     <= v1_next;
			v2_reg     <= v2_next;
			word_reg   <= word_next;
			wvalid_reg <= wvalid_next;
		end
	end

endmodule

/* csd_dev.sv */
// Coprocessor end: decodes subtract instructions, loads operands and writes the difference.
module csd_dev #(
	parameter int          DATA_W = 32,
	parameter logic [2:0]  SEL_CODE = 3'h0
) (
	input  wire logic              sys_clk_i,
	input  wire logic              arst_n_i,
	csd_link_if.dev_mp             link,
	output logic                   result_valid_o,
	output logic [4:0]             result_dst_o,
	output logic [DATA_W-1:0]      result_o,
	output logic                   result_float_o,
	output logic                   result_double_o,
	output logic [DATA_W-1:0]      bank_one_o,
	output logic [DATA_W-1:0]      bank_two_o
);

	typedef enum logic [1:0] {
		DEV_IDLE  = 2'b00,
		DEV_FIRST = 2'b01,
		DEV_SECND = 2'b10,
		DEV_EXEC  = 2'b11
	} dev_state_t;

	// Decoded form of one instruction word.
	typedef struct packed {
		logic              ok;
		logic              load;
		csd_pkg::csd_op_t  op;
	} csd_dec_t;

	// Decode the opcode half-word and select field of an instruction.
	function automatic csd_dec_t decode(input logic [31:0] w, input logic [2:0] code);
		csd_dec_t   d;
		logic [3:0] grp;
		logic [2:0] opc;
		logic       t;
		logic       s;
		d   = '{ok: 1'b0, load: 1'b0, op: csd_pkg::CSD_OP_NONE};
		grp = w[csd_pkg::GRP_HI:csd_pkg::GRP_LO];
		opc = w[csd_pkg::OPC_HI:csd_pkg::OPC_LO];
		t   = w[csd_pkg::TYPE_BIT];
		s   = w[csd_pkg::SIZE_BIT];
		if (w[csd_pkg::SEL_HI:csd_pkg::SEL_LO] == code) begin
			case (grp)
				csd_pkg::GRP_HOST: begin
					// Host-register loads carry no size bit; single or integer only.
					if (!s && (opc == csd_pkg::OPC_TWO_MINUS_ONE)) begin
						d = '{ok: 1'b1, load: 1'b1, op: csd_pkg::CSD_OP_TWO_ONE};
					end else if (!s && (opc == csd_pkg::OPC_ONE_MINUS_TWO)) begin
						d = '{ok: 1'b1, load: 1'b1, op: csd_pkg::CSD_OP_ONE_TWO};
					end
				end
				csd_pkg::GRP_MEM: begin
					if (opc == csd_pkg::OPC_ONE_MINUS_TWO) begin
						d = '{ok: 1'b1, load: 1'b1, op: csd_pkg::CSD_OP_ONE_TWO};
					end else if (opc == csd_pkg::OPC_TWO_MINUS_ONE) begin
						d = '{ok: 1'b1, load: 1'b1, op: csd_pkg::CSD_OP_TWO_ONE};
					end
				end
				csd_pkg::GRP_REG: begin
					// Magnitude form needs a floating type; the type bit flags floating.
					// A plain register subtract without a load is not handled by this block,
					// so it falls through and the host sees an illegal pulse.
					if ({opc, t} == csd_pkg::OPC_MAGNITUDE) begin
						d = '{ok: 1'b1, load: 1'b0, op: csd_pkg::CSD_OP_MAGNITUDE};
					end
				end
				default: d.ok = 1'b0;
			endcase
		end
		return d;
	endfunction

	dev_state_t        state_reg, state_next;
	csd_pkg::csd_op_t  op_reg, op_next;
	logic [4:0]        dst_reg, dst_next;
	logic              flt_reg, flt_next;
	logic              dbl_reg, dbl_next;
	logic [DATA_W-1:0] one_reg, one_next;
	logic [DATA_W-1:0] two_reg, two_next;
	logic [DATA_W-1:0] res_reg, res_next;
	logic              rvalid_reg, rvalid_next;
	logic              ill_reg, ill_next;
	logic [DATA_W-1:0] diff;
	csd_dec_t          dec;

	// The word is decoded every cycle, but only the idle state acts on it.
	assign dec = decode(link.instr, SEL_CODE);
	assign link.instr_ready = (state_reg == DEV_IDLE);
	assign link.data_ready  = (state_reg == DEV_FIRST) || (state_reg == DEV_SECND);
	assign link.done        = rvalid_reg;
	assign link.illegal     = ill_reg;
	assign result_valid_o   = rvalid_reg;
	assign result_dst_o     = dst_reg;
	assign result_o         = res_reg;
	assign result_float_o   = flt_reg;
	assign result_double_o  = dbl_reg;
	assign bank_one_o       = one_reg;
	assign bank_two_o       = two_reg;

	// Subtract order follows the opcode; integer arithmetic stands for the arithmetic core.
	always_comb begin
		if (op_reg == csd_pkg::CSD_OP_TWO_ONE) begin
			diff = two_reg - one_reg;
		end else begin
			diff = one_reg - two_reg;
		end
	end

	// Sequencer: decode, optional two operand words, then one execute cycle.
	always_comb begin
		state_next  = state_reg;
		op_next     = op_reg;
		dst_next    = dst_reg;
		flt_next    = flt_reg;
		dbl_next    = dbl_reg;
		one_next    = one_reg;
		two_next    = two_reg;
		res_next    = res_reg;
		rvalid_next = 1'b0;
		ill_next    = 1'b0;
		case (state_reg)
			DEV_IDLE: begin
				if (link.instr_valid) begin
					if (dec.ok) begin
						op_next    = dec.op;
						dst_next   = link.instr[csd_pkg::DST_HI:csd_pkg::DST_LO];
						flt_next   = link.instr[csd_pkg::TYPE_BIT];
						dbl_next   = link.instr[csd_pkg::SIZE_BIT];
						state_next = dec.load ? DEV_FIRST : DEV_EXEC;
					end else begin
						// A refused word leaves every operand and result register untouched.
						ill_next = 1'b1;
					end
				end
			end
			DEV_FIRST: begin
				if (link.data_valid) begin
					one_next   = link.data;
					state_next = DEV_SECND;
				end
			end
			DEV_SECND: begin
				if (link.data_valid) begin
					two_next   = link.data;
					state_next = DEV_EXEC;
				end
			end
			DEV_EXEC: begin
				// Both operands are complete here, so no half-loaded pair is ever subtracted.
				// The most negative difference has no positive twin and wraps to itself.
				if (op_reg == csd_pkg::CSD_OP_MAGNITUDE && diff[DATA_W-1]) begin
					res_next = '0 - diff;
				end else begin
					res_next = diff;
				end
				rvalid_next = 1'b1;
				state_next  = DEV_IDLE;
			end
			default: state_next = DEV_IDLE;
		endcase
	end

	// State registers.
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg  <= DEV_IDLE;
			op_reg     <= csd_pkg::CSD_OP_NONE;
			dst_reg    <= '0;
			flt_reg    <= 1'b0;
			dbl_reg    <= 1'b0;
			one_reg    <= '0;
			two_reg    <= '0;
			res_reg    <= '0;
			rvalid_reg <= 1'b0;
			ill_reg    <= 1'b0;
		end else begin
			state_reg  <= state_next;
			op_reg     <= op_next;
			dst_reg    <= dst_next;
			flt_reg    <= flt_next;
			dbl_reg    <= dbl_next;
			one_reg    <= one_next;
			two_reg    <= two_next;
			res_reg    <= res_next;
			rvalid_reg <= rvalid_next;
			ill_reg    <= ill_next;
		end
	end

endmodule

/* csd_checker.sv */
// Checker of the link timing between the host and coprocessor ends.
module csd_checker (
	input wire logic        sys_clk_i,
	input wire logic        arst_n_i,
	input wire logic        instr_valid,
	input wire logic [31:0] instr,
	input wire logic        instr_ready,
	input wire logic        data_valid,
	input wire logic        data_ready,
	input wire logic        done,
	input wire logic        illegal
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!arst_n_i);

	// Instruction taken this cycle, and its group and opcode fields.
	logic       tk;
	logic       sel0;
	logic [3:0] grp;
	logic [2:0] opc;
	assign tk   = instr_valid & instr_ready;
	assign sel0 = instr[31:29] == 3'h0;
	assign grp  = instr[15:12];
	assign opc  = instr[11:9];

	// Counts operand words; the second word of a pair starts execution.
	logic wc_reg;
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wc_reg <= 1'b0;
		end else if (data_valid && data_ready) begin
			wc_reg <= !wc_reg;
		end
	end

	sel_refused_a: assert property (tk && !sel0 |=> illegal && !data_ready)
		else $error("foreign select not refused");
	dbl_load_refused_a: assert property (tk && sel0 && grp == 4'h4 && instr[7] |=> illegal)
		else $error("double host load not refused");
	int_mag_refused_a: assert property (tk && sel0 && grp == 4'h0 && opc == 3'h5 && !instr[8]
		|=> illegal)
		else $error("integer magnitude not refused");
	mag_done_a: assert property (tk && sel0 && grp == 4'h0 && instr[11:8] == 4'hB
		|=> !done && !illegal ##1 done)
		else $error("magnitude form late");
	reg_sub_refused_a: assert property (tk && sel0 && grp == 4'h0 && (opc == 3'h1 || opc == 3'h3)
		|=> illegal && !data_ready)
		else $error("plain register subtract not refused");
	refused_no_data_a: assert property (illegal |=> !data_valid && !done)
		else $error("operand word or result after refusal");
	load_waits_a: assert property (tk && sel0 && (grp == 4'h8 || grp == 4'h4 && !instr[7])
		&& (opc == 3'h1 || opc == 3'h3) |=> data_ready && !done)
		else $error("load did not ask for operands");
	no_early_done_a: assert property (data_ready |-> !done)
		else $error("done while operands pending");
	second_word_a: assert property (data_valid && data_ready && wc_reg |=> !done ##1 done)
		else $error("done not two cycles after second word");
	pulse_once_a: assert property (done || illegal |=> !done && !illegal)
		else $error("completion pulse too long");
endmodule

/* testbench.sv */
// Self-checking bench joining the host and coprocessor ends across the link.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic              sys_clk    = 1'b0;
	logic              arst_n     = 1'b0;
	logic              req_valid  = 1'b0;
	logic [31:0]       req_instr  = 32'h00000000;
	csd_pkg::csd_src_t req_src    = csd_pkg::CSD_SRC_NONE;
	logic [31:0]       req_first  = 32'h00000000;
	logic [31:0]       req_second = 32'h00000000;
	logic [31:0]       req_ptr    = 32'h00000000;
	logic              req_ready;
	logic [31:0]       mem_addr;
	logic              mem_rd;
	logic [31:0]       mem_data;
	logic [31:0]       ptr;
	logic              busy;
	logic              res_valid;
	logic [4:0]        res_dst;
	logic [31:0]       res;
	logic              res_float;
	logic              res_double;
	logic [31:0]       bank_one;
	logic [31:0]       bank_two;
	logic [31:0]       m1         = 32'h00000000;
	logic [31:0]       m2         = 32'h00000000;
	int                error_cnt  = 0;
	int                n_compared = 0;
	// Kinds: {bad select, size, source, group, opcode nibble}.
	logic [11:0]       kinds [13] = '{12'h147, 12'h146, 12'h143, 12'h547, 12'h282, 12'h287,
		12'h383, 12'h386, 12'h003, 12'h006, 12'h00B, 12'h00A, 12'h803};
	csd_link_if lnk ();

	// Free-running clock at 125 MHz.
	always #4 sys_clk = ~sys_clk;

	// Memory answers from the address; released, it shows the inverse so stale data never matches.
	function automatic logic [31:0] mf(input logic [31:0] a);
		return (a * 32'h00019E37) ^ 32'h5A5A0F0F;
	endfunction
	assign mem_data = mem_rd ? mf(mem_addr) : ~mf(mem_addr);

	csd_host csd_host_inst (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .link(lnk),
		.req_valid_i(req_valid), .req_instr_i(req_instr), .req_src_i(req_src),
		.req_first_i(req_first), .req_second_i(req_second), .req_ptr_i(req_ptr),
		.req_ready_o(req_ready), .mem_addr_o(mem_addr), .mem_rd_o(mem_rd),
		.mem_data_i(mem_data), .ptr_o(ptr), .busy_o(busy));
	csd_dev csd_dev_inst (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .link(lnk),
		.result_valid_o(res_valid), .result_dst_o(res_dst), .result_o(res),
		.result_float_o(res_float), .result_double_o(res_double),
		.bank_one_o(bank_one), .bank_two_o(bank_two));
	csd_checker csd_checker_inst (.sys_clk_i(sys_clk), .arst_n_i(arst_n),
		.instr_valid(lnk.instr_valid), .instr(lnk.instr), .instr_ready(lnk.instr_ready),
		.data_valid(lnk.data_valid), .data_ready(lnk.data_ready), .done(lnk.done),
		.illegal(lnk.illegal));

	task automatic complete_run();
		$display("Compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// A wait that used up its bound ends the run as a failure.
	task automatic guard(input int n);
		if (n >= 40) begin
			error_cnt++;
			$display("BAD wait expected answer seen timeout");
			complete_run();
		end
	endtask

	// One instruction of the given kind with random fields, checked against the model.
	task automatic run(input int k);
		logic [11:0] e;
		logic [31:0] w, a, b, p, x, y, d, r;
		logic [2:0]  op;
		logic        ok;
		int          n;
		e = kinds[k];
		a = $urandom();
		b = $urandom();
		p = $urandom();
		w = {3'h0, 13'($urandom()), e[7:0], 8'h00};
		if (e[11]) w[31:29] = 3'($urandom_range(7, 1));
		w[7] = e[7:4] == 4'h4 ? e[10] : 1'($urandom());
		op = w[11:9];
		// Group 0 holds only the magnitude form; a plain register subtract is refused.
		ok = w[31:29] == 3'h0 && !(e[7:4] == 4'h4 && w[7])
			&& (e[7:4] == 4'h0 ? w[11:8] == 4'hB : (op == 3'h1 || op == 3'h3));
		x = e[9:8] == 2'h1 ? a : e[9:8] == 2'h2 ? mf(p) : mf(p - 32'h20);
		y = e[9:8] == 2'h1 ? b : e[9:8] == 2'h2 ? mf(p + 32'h20) : mf(p - 32'h40);
		if (ok && e[9:8] != 2'h0) m1 = x;
		if (ok && e[9:8] != 2'h0) m2 = y;
		d = m1 - m2;
		r = op == 3'h3 ? m2 - m1 : op == 3'h1 ? d : ($signed(d) < 0 ? -d : d);
		@(negedge sys_clk);
		for (n = 0; n < 40 && req_ready !== 1'b1; n++) @(negedge sys_clk);
		guard(n);
		req_valid = 1'b1;
		req_instr = w;
		req_src = csd_pkg::csd_src_t'(e[9:8]);
		req_first = a;
		req_second = b;
		req_ptr = p;
		@(negedge sys_clk);
		req_valid = 1'b0;
		for (n = 0; n < 40 && res_valid !== 1'b1 && lnk.illegal !== 1'b1; n++) @(negedge sys_clk);
		guard(n);
		chk("illegal", 32'(!ok), 32'(lnk.illegal));
		chk("busy", 32'h00000001, 32'(busy));
		chk("bank_one", m1, bank_one);
		chk("bank_two", m2, bank_two);
		if (ok) begin
			chk("result", r, res);
			chk("dst", 32'(w[20:16]), 32'(res_dst));
			chk("float", 32'(w[8]), 32'(res_float));
			chk("double", 32'(w[7]), 32'(res_double));
			if (e[9]) chk("ptr", e[8] ? p - 32'h40 : p + 32'h40, ptr);
		end
	endtask

	// Reset, one pass over every kind, then random kinds back to back.
	initial begin
		void'($urandom(32'h8456));
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk);
		arst_n = 1'b1;
		for (int i = 0; i < 60; i++) begin
			run(i < 13 ? i : $urandom_range(12, 0));
		end
		complete_run();
	end
endmodule
